// [rtl/twp_decoder.sv]
/*
 * Two-word prefix decoder. Recognises the prefix pair offered by the
 * dispatcher, extracts count, condition, loop markers and bank bits, and
 * registers slot enables and extended register numbers one cycle later.
 * Assumes the dispatcher offers both words, the set-start flag, the true
 * flag and the slot operand fields together, on clk, for one cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module twp_decoder
	import twp_pkg::*;
#(
	parameter int DUNITS = DATA_ARITH_UNIT_N,        // Data-arithmetic units
	parameter int AUNITS = AGU_N          // Address-generation units
)
(
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire logic                          setValid,
	input  wire logic                          setStart,
	input  wire logic                          tFlag,
	input  wire logic [WORD_W-1:0]             firstWord,
	input  wire logic [WORD_W-1:0]             secondWord,
	input  wire logic [DUNITS-1:0][1:0]        daluForm,
	input  wire logic [DUNITS-1:0][2:0]        daluFieldA,
	input  wire logic [DUNITS-1:0][2:0]        daluFieldB,
	input  wire logic [DUNITS-1:0][2:0]        daluFieldC,
	input  wire logic [AUNITS-1:0][AOP_N-1:0][2:0] aguKind,
	input  wire logic [AUNITS-1:0][AOP_N-1:0][3:0] aguCode,
	output logic                               decodeValid,
	output logic                               prefixHit,
	output logic                               prefixConsumed,
	output logic [2:0]                         groupCount,
	output logic [2:0]                         instrWords,
	output logic                               escapeCode,
	output logic                               reservedPlace,
	output logic                               reservedCond,
	output logic                               loopEndMarker,
	output logic                               loopEarlyMarker,
	output logic [SLOT_N-1:0]                  slotEnable,
	output logic [DUNITS-1:0][3:0]             daluRegA,
	output logic [DUNITS-1:0][3:0]             daluRegB,
	output logic [DUNITS-1:0][3:0]             daluRegC,
	output logic [AUNITS-1:0][AOP_N-1:0][3:0]  aguReg
);

	// Slot enables for one condition code and true flag
	function automatic logic [SLOT_N-1:0] cond_slots(
		input logic [2:0] code,
		input logic       tVal
	);
		logic [SLOT_N-1:0] grp;
		grp = tVal ? SLOTS_GRP0 : ~SLOTS_GRP0;
		case (code)
			CC_ALWAYS:  cond_slots = SLOTS_ALL;
			CC_ALL_T:   cond_slots = tVal ? SLOTS_ALL : SLOTS_NONE;
			CC_ALL_F:   cond_slots = tVal ? SLOTS_NONE : SLOTS_ALL;
			CC_SPLIT:   cond_slots = grp;
			CC_FIRST_T: cond_slots = tVal ? SLOTS_ALL : ~SLOTS_GRP0;
			CC_FIRST_F: cond_slots = tVal ? ~SLOTS_GRP0 : SLOTS_ALL;
			// Reserved codes simply run everything; no trap is raised
			default:    cond_slots = SLOTS_ALL;
		endcase
	endfunction

	// Field views of the offered words
	logic              tagHit;           // Both fixed tags match and the zero bit is clear
	logic [2:0]        cntField;         // Group count field
	logic [2:0]        condField;        // Set condition field
	logic [AUNITS-1:0] aguPrimary;       // Primary bank bit per unit
	logic [AUNITS-1:0] aguSecondary;     // Secondary bank bit per unit
	logic [DUNITS-1:0][2:0] daluExt;     // Extension field per data unit

	// Recognise the prefix by its fixed bits
	always_comb
	begin
		tagHit = (firstWord[W1_TAG_MSB:W1_TAG_LSB] == W1_TAG_VAL)
			&& !firstWord[W1_ZERO_BIT]
			&& (secondWord[W2_TAG_MSB:W2_TAG_LSB] == W2_TAG_VAL);
		cntField  = firstWord[W1_AAA_MSB:W1_AAA_LSB];
		condField = firstWord[W1_CCC_MSB:W1_CCC_LSB];
	end

	// Bank bits; a word that is not a prefix extends nothing
	always_comb
	begin
		aguPrimary   = '0;
		aguSecondary = '0;
		if (tagHit)
		begin
			aguPrimary[0]   = firstWord[W1_H_BIT];
			aguSecondary[0] = firstWord[W1_HS_BIT];
			aguPrimary[1]   = secondWord[W2_TP_BIT];
			aguSecondary[1] = firstWord[W1_TS_BIT];
		end
	end

	// Each data unit reads its own three bits, first-named on top
	always_comb
	begin
		daluExt = '0;
		for (int u = 0; u < DUNITS; u++)
		begin
			if (tagHit)
				daluExt[u] = {secondWord[W2_DX_HI + u],
					secondWord[W2_DX_MID + u],
					secondWord[W2_DX_LO + u]};
		end
	end

	// Combinational extended register numbers from the helpers
	logic [DUNITS-1:0][3:0]            extA;    // Data operand A
	logic [DUNITS-1:0][3:0]            extB;    // Data operand B
	logic [DUNITS-1:0][3:0]            extC;    // Data operand C
	logic [AUNITS-1:0][AOP_N-1:0][3:0] extAgu;  // Address operands

	// One data helper per unit
	for (genvar u = 0; u < DUNITS; u++)
	begin : g_data_arith_unit
		twp_data_arith_unit_ext u_data_arith_unit (
			.extBits (daluExt[u]),
			.opForm  (twp_dop_t'(daluForm[u])),
			.fieldA  (daluFieldA[u]),
			.fieldB  (daluFieldB[u]),
			.fieldC  (daluFieldC[u]),
			.regA    (extA[u]),
			.regB    (extB[u]),
			.regC    (extC[u])
		);
	end

	// One address helper per operand of each unit
	for (genvar a = 0; a < AUNITS; a++)
	begin : g_agu
		for (genvar k = 0; k < AOP_N; k++)
		begin : g_op
			twp_agu_ext u_agu (
				.primaryExt   (aguPrimary[a]),
				.secondaryExt (aguSecondary[a]),
				.fieldKind    (twp_akind_t'(aguKind[a][k])),
				.regCode      (aguCode[a][k]),
				.regOut       (extAgu[a][k])
			);
		end
	end

	// Next values of the registered decode
	logic                              next_decodeValid;
	logic                              next_prefixHit;
	logic                              next_prefixConsumed;
	logic [2:0]                        next_groupCount;
	logic [2:0]                        next_instrWords;
	logic                              next_escapeCode;
	logic                              next_reservedPlace;
	logic                              next_reservedCond;
	logic                              next_loopEndMarker;
	logic                              next_loopEarlyMarker;
	logic [SLOT_N-1:0]                 next_slotEnable;
	logic [DUNITS-1:0][3:0]            next_daluRegA;
	logic [DUNITS-1:0][3:0]            next_daluRegB;
	logic [DUNITS-1:0][3:0]            next_daluRegC;
	logic [AUNITS-1:0][AOP_N-1:0][3:0] next_aguReg;

	// Decode step: fields held until the next offered set
	always_comb
	begin
		next_decodeValid     = setValid;
		next_prefixHit       = prefixHit;
		next_prefixConsumed  = 1'b0;
		next_groupCount      = groupCount;
		next_instrWords      = instrWords;
		next_escapeCode      = escapeCode;
		next_reservedPlace   = reservedPlace;
		next_reservedCond    = reservedCond;
		next_loopEndMarker   = loopEndMarker;
		next_loopEarlyMarker = loopEarlyMarker;
		next_slotEnable      = slotEnable;
		next_daluRegA        = daluRegA;
		next_daluRegB        = daluRegB;
		next_daluRegC        = daluRegC;
		next_aguReg          = aguReg;
		if (setValid)
		begin
			next_prefixHit      = tagHit;
			// Both words are swallowed here, no slot ever sees them
			next_prefixConsumed = tagHit;
			next_daluRegA       = extA;
			next_daluRegB       = extB;
			next_daluRegC       = extC;
			next_aguReg         = extAgu;
			if (tagHit)
			begin
				next_groupCount = cntField;
				// Escape counts announce more prefix words, not a size
				next_escapeCode = setStart
					&& (cntField <= AAA_ESC_MAX);
				next_instrWords = next_escapeCode ? 3'h0
					: cntField - PFX_WORDS_M1;
				// Mid-set placement is flagged, never treated as padding
				next_reservedPlace = !setStart;
				next_reservedCond  = (condField == CC_RSV_A)
					|| (condField == CC_RSV_B);
				// Markers are passed through to loop control as written
				next_loopEndMarker   = firstWord[W1_END_BIT];
				next_loopEarlyMarker = firstWord[W1_EARLY_BIT];
				next_slotEnable = cond_slots(condField, tFlag);
			end
			else
			begin
				next_groupCount      = 3'h0;
				next_instrWords      = 3'h0;
				next_escapeCode      = 1'b0;
				next_reservedPlace   = 1'b0;
				next_reservedCond    = 1'b0;
				next_loopEndMarker   = 1'b0;
				next_loopEarlyMarker = 1'b0;
				next_slotEnable      = SLOTS_ALL;
			end
		end
	end

	// Register stage; all outputs come from here
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			decodeValid     <= 1'b0;
			prefixHit       <= 1'b0;
			prefixConsumed  <= 1'b0;
			groupCount      <= 3'h0;
			instrWords      <= 3'h0;
			escapeCode      <= 1'b0;
			reservedPlace   <= 1'b0;
			reservedCond    <= 1'b0;
			loopEndMarker   <= 1'b0;
			loopEarlyMarker <= 1'b0;
			slotEnable      <= SLOTS_ALL;
			daluRegA        <= '0;
			daluRegB        <= '0;
			daluRegC        <= '0;
			aguReg          <= '0;
		end
		else
		begin
			decodeValid     <= next_decodeValid;
			prefixHit       <= next_prefixHit;
			prefixConsumed  <= next_prefixConsumed;
			groupCount      <= next_groupCount;
			instrWords      <= next_instrWords;
			escapeCode      <= next_escapeCode;
			reservedPlace   <= next_reservedPlace;
			reservedCond    <= next_reservedCond;
			loopEndMarker   <= next_loopEndMarker;
			loopEarlyMarker <= next_loopEarlyMarker;
			slotEnable      <= next_slotEnable;
			daluRegA        <= next_daluRegA;
			daluRegB        <= next_daluRegB;
			daluRegC        <= next_daluRegC;
			aguReg          <= next_aguReg;
		end
	end

	// Helper views for the checks below
	logic       hitNow;     // Prefix offered this cycle
	logic [2:0] u0Ext;      // Unit 0 data extension bits
	logic       u0Three;    // Unit 0 holds a three-operand instruction
	logic       a1Index;    // Unit 1 operand 0 is an index pointer
	assign hitNow  = setValid && tagHit;
	assign u0Ext   = daluExt[0];
	assign u0Three = (daluForm[0] == DOP_THREE);
	assign a1Index = (aguKind[1][0] == AK_INDEX);

	property p_count;
		@(posedge clk) disable iff (!rst_b)
		hitNow && !(setStart && cntField <= AAA_ESC_MAX)
		|=> groupCount == $past(cntField)
			&& instrWords == groupCount - PFX_WORDS_M1;
	endproperty
	a_count: assert property (p_count)
		else $error("group count or word count wrong");

	property p_escape;
		@(posedge clk) disable iff (!rst_b)
		hitNow && setStart && cntField <= AAA_ESC_MAX
		|=> escapeCode && instrWords == 3'h0;
	endproperty
	a_escape: assert property (p_escape)
		else $error("escape count decoded as size");

	property p_whole;
		@(posedge clk) disable iff (!rst_b)
		hitNow && (condField == CC_ALL_T || condField == CC_ALL_F)
		|=> slotEnable == (($past(tFlag) == ($past(condField) == CC_ALL_T))
			? SLOTS_ALL : SLOTS_NONE);
	endproperty
	a_whole: assert property (p_whole)
		else $error("whole-set condition wrong");

	property p_split;
		@(posedge clk) disable iff (!rst_b)
		hitNow && condField == CC_SPLIT
		|=> slotEnable == ($past(tFlag) ? SLOTS_GRP0 : ~SLOTS_GRP0);
	endproperty
	a_split: assert property (p_split)
		else $error("split condition wrong");

	property p_first;
		@(posedge clk) disable iff (!rst_b)
		hitNow && condField == CC_FIRST_F && tFlag
		|=> (slotEnable & SLOTS_GRP0) == SLOTS_NONE
			&& (slotEnable & ~SLOTS_GRP0) == ~SLOTS_GRP0;
	endproperty
	a_first: assert property (p_first)
		else $error("first-group condition wrong");

	property p_data_arith_unit;
		@(posedge clk) disable iff (!rst_b)
		hitNow && u0Three
		|=> daluRegC[0][3] == $past(u0Ext[0])
			&& daluRegA[0][3] == $past(u0Ext[1])
			&& daluRegB[0][3] == $past(u0Ext[2]);
	endproperty
	a_data_arith_unit: assert property (p_data_arith_unit)
		else $error("data bank bit misplaced");

	property p_index;
		@(posedge clk) disable iff (!rst_b)
		setValid && a1Index |=> aguReg[1][0][3] == 1'b0;
	endproperty
	a_index: assert property (p_index)
		else $error("index pointer extended");

	property p_consume;
		@(posedge clk) disable iff (!rst_b)
		decodeValid |-> prefixConsumed == prefixHit;
	endproperty
	a_consume: assert property (p_consume)
		else $error("prefix consume mismatch");

	property p_nohit;
		@(posedge clk) disable iff (!rst_b)
		setValid && !tagHit |=> !prefixHit && slotEnable == SLOTS_ALL
			&& !loopEndMarker && !loopEarlyMarker;
	endproperty
	a_nohit: assert property (p_nohit)
		else $error("non-prefix decoded as prefix");

endmodule

`default_nettype wire

// [rtl/twp_pkg.sv]
/*
 * Shared constants and types for the two-word prefix decoder: fixed tag
 * values, field bit positions, condition codes and operand kinds.
 * Assumes prefix words are 16 bits wide, first word first.
 */
`default_nettype none

package twp_pkg;

	// Word geometry
	localparam int WORD_W = 16;            // Width of one prefix word
	localparam int SLOT_N = 6;             // Four data slots, two address slots
	localparam int DATA_ARITH_UNIT_N = 4;             // Data-arithmetic units
	localparam int AGU_N  = 2;             // Address-generation units
	localparam int AOP_N  = 2;             // Operands per address unit

	// First word: fixed tag and field positions
	localparam int          W1_TAG_MSB  = 15;
	localparam int          W1_TAG_LSB  = 12;
	localparam logic [3:0]  W1_TAG_VAL  = 4'h3;
	localparam int          W1_ZERO_BIT = 8;     // Must read as zero
	localparam int          W1_AAA_MSB  = 11;
	localparam int          W1_AAA_LSB  = 9;
	localparam int          W1_H_BIT    = 7;     // Address unit 0 primary
	localparam int          W1_TS_BIT   = 6;     // Address unit 1 secondary
	localparam int          W1_HS_BIT   = 5;     // Address unit 0 secondary
	localparam int          W1_EARLY_BIT = 4;    // Early loop marker
	localparam int          W1_END_BIT  = 3;     // End loop marker
	localparam int          W1_CCC_MSB  = 2;
	localparam int          W1_CCC_LSB  = 0;

	// Second word: fixed tag and field positions
	localparam int          W2_TAG_MSB  = 15;
	localparam int          W2_TAG_LSB  = 13;
	localparam logic [2:0]  W2_TAG_VAL  = 3'h5;
	localparam int          W2_TP_BIT   = 8;     // Address unit 1 primary
	// Data unit u extension bits sit at {HI+u, MID+u, LO+u}, first-named MSB
	localparam int          W2_DX_HI    = 9;
	localparam int          W2_DX_MID   = 4;
	localparam int          W2_DX_LO    = 0;

	// Group count escape codes and instruction word offset
	localparam logic [2:0]  AAA_ESC_MAX = 3'h1;  // Counts 0 and 1 escape
	localparam logic [2:0]  PFX_WORDS_M1 = 3'h1; // Prefix words minus one

	// Set condition codes
	localparam logic [2:0]  CC_ALWAYS   = 3'h0;
	localparam logic [2:0]  CC_SPLIT    = 3'h1;
	localparam logic [2:0]  CC_ALL_T    = 3'h2;
	localparam logic [2:0]  CC_ALL_F    = 3'h3;
	localparam logic [2:0]  CC_RSV_A    = 3'h4;
	localparam logic [2:0]  CC_RSV_B    = 3'h5;
	localparam logic [2:0]  CC_FIRST_T  = 3'h6;
	localparam logic [2:0]  CC_FIRST_F  = 3'h7;

	// Slot order: bit0..3 data slots 0..3, bit4..5 address slots 0..1
	localparam logic [5:0]  SLOTS_ALL   = 6'h3f;
	localparam logic [5:0]  SLOTS_NONE  = 6'h00;
	localparam logic [5:0]  SLOTS_GRP0  = 6'h15; // Data 0, data 2, address 0

	// Data operand count of the instruction in a data slot
	typedef enum logic [1:0] {DOP_ONE, DOP_TWO, DOP_THREE, DOP_FOUR} twp_dop_t;

	// How an address-unit operand field is encoded
	typedef enum logic [2:0] {
		AK_PTR,       // Three-bit pointer field
		AK_WIDE,      // Four-bit register field
		AK_CTRLDATA,  // Data operand of long control-register move
		AK_OTHER,     // Any other operand
		AK_GROUP,     // Register pair or group field
		AK_INDEX      // Index pointer of pointer-plus-register mode
	} twp_akind_t;

endpackage

`default_nettype wire

// [rtl/twp_data_arith_unit_ext.sv]
/*
 * Bank extension for one data-arithmetic slot: joins the three extension
 * bits onto the three-bit register fields. Purely combinational; the
 * caller registers the results.
 */
`timescale 1ns/10ps
`default_nettype none

module twp_data_arith_unit_ext
	import twp_pkg::*;
(
	input  wire logic [2:0] extBits,   // First-named bit in the MSB
	input  wire twp_dop_t   opForm,    // Operand count of the instruction
	input  wire logic [2:0] fieldA,    // First operand field
	input  wire logic [2:0] fieldB,    // Second operand field
	input  wire logic [2:0] fieldC,    // Third operand field
	output logic      [3:0] regA,      // Extended first operand
	output logic      [3:0] regB,      // Extended second operand
	output logic      [3:0] regC       // Extended third operand
);

	// Named views of the three bits, first-named on top
	logic bitFirst;                    // Second-operand bank in 3-op form
	logic bitMid;                      // First-operand bank in 3-op form
	logic bitLast;                     // Last-operand bank
	assign bitFirst = extBits[2];
	assign bitMid   = extBits[1];
	assign bitLast  = extBits[0];

	// Each bit is a fourth, top register bit chosen per operand
	always_comb
	begin
		regA = {1'b0, fieldA};
		regB = {1'b0, fieldB};
		regC = {1'b0, fieldC};
		case (opForm)
			DOP_THREE:
			begin
				regA = {bitMid, fieldA};
				regB = {bitFirst, fieldB};
				regC = {bitLast, fieldC};
			end
			// Four-operand forms present their data pair in A and B
			DOP_TWO, DOP_FOUR:
			begin
				regA = {bitFirst, fieldA};
				regB = {bitLast, fieldB};
			end
			DOP_ONE:
				regA = {bitLast, fieldA};
			default:
				regA = {1'b0, fieldA};
		endcase
	end

endmodule

`default_nettype wire

// [rtl/twp_agu_ext.sv]
/*
 * Bank extension for one address-unit operand field. Chooses between the
 * primary and secondary bit by field kind. Purely combinational; the
 * caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none

module twp_agu_ext
	import twp_pkg::*;
(
	input  wire logic       primaryExt,   // Primary bank bit of the unit
	input  wire logic       secondaryExt, // Secondary bank bit of the unit
	input  wire twp_akind_t fieldKind,    // How the field is encoded
	input  wire logic [3:0] regCode,      // Raw field, 3-bit kinds use [2:0]
	output logic      [3:0] regOut        // Extended register number
);

	// Kind decides which bit applies; a group moves as one base number
	always_comb
	begin
		regOut = regCode;
		case (fieldKind)
			AK_PTR, AK_CTRLDATA:
				regOut = {primaryExt, regCode[2:0]};
			AK_WIDE:
			begin
				// Upper codes name non-pointer registers and stay as is
				if (!regCode[3])
					regOut = {primaryExt, regCode[2:0]};
				else
					regOut = regCode;
			end
			AK_OTHER:
				regOut = {secondaryExt, regCode[2:0]};
			AK_GROUP:
				regOut = {secondaryExt, regCode[2:0]};
			AK_INDEX:
				regOut = {1'b0, regCode[2:0]};
			default:
				regOut = regCode;
		endcase
	end

endmodule

`default_nettype wire

// [testbench/twp_fetch_model.sv]
/*
 * Stand-in for fetch and dispatch: offers one set's prefix words, start
 * flag and true flag to the decoder one clock after a bench request.
 * Assumes requests arrive on the rising edge of clk.
 */
`timescale 1ns/10ps
`default_nettype none

module twp_fetch_model
	import twp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              req,
	input  wire logic              startIn,
	input  wire logic              tIn,
	input  wire logic [WORD_W-1:0] w1In,
	input  wire logic [WORD_W-1:0] w2In,
	output logic                   setValid,
	output logic                   setStart,
	output logic                   tFlag,
	output logic [WORD_W-1:0]      firstWord,
	output logic [WORD_W-1:0]      secondWord
);
	// Idle words invert each cycle, so stale data matches the last set's words only every second idle cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			setValid   <= 1'b0;
			setStart   <= 1'b0;
			tFlag      <= 1'b0;
			firstWord  <= '0;
			secondWord <= '0;
		end
		else
		begin
			setValid   <= req;
			setStart   <= startIn;
			tFlag      <= tIn;
			firstWord  <= req ? w1In : ~firstWord;
			secondWord <= req ? w2In : ~secondWord;
		end
	end
endmodule

`default_nettype wire

// [testbench/twp_decoder_test.sv]
/*
 * Self-checking bench for the prefix decoder: sequences of set offers
 * through the fetch stand-in, each followed by checks of the outputs.
 * Assumes the decoder answers one clock after setValid.
 */
`timescale 1ns/10ps
`default_nettype none

module twp_decoder_test
	import twp_pkg::*;
;
	logic clk, rst_b, req, startIn, tIn, setValid, setStart, tFlag;
	logic [WORD_W-1:0] w1In, w2In, firstWord, secondWord;
	logic [DATA_ARITH_UNIT_N-1:0][1:0] daluForm;
	logic [DATA_ARITH_UNIT_N-1:0][2:0] daluFieldA, daluFieldB, daluFieldC;
	logic [AGU_N-1:0][AOP_N-1:0][2:0] aguKind;
	logic [AGU_N-1:0][AOP_N-1:0][3:0] aguCode, aguReg;
	logic decodeValid, prefixHit, prefixConsumed, escapeCode;
	logic reservedPlace, reservedCond, loopEndMarker, loopEarlyMarker;
	logic [2:0] groupCount, instrWords;
	logic [SLOT_N-1:0] slotEnable;
	logic [DATA_ARITH_UNIT_N-1:0][3:0] daluRegA, daluRegB, daluRegC;
	int mismatches, checks_done;

	twp_fetch_model model (.clk, .rst_b, .req, .startIn, .tIn, .w1In,
		.w2In, .setValid, .setStart, .tFlag, .firstWord, .secondWord);
	twp_decoder dut (.clk, .rst_b, .setValid, .setStart, .tFlag,
		.firstWord, .secondWord, .daluForm, .daluFieldA, .daluFieldB,
		.daluFieldC, .aguKind, .aguCode, .decodeValid, .prefixHit,
		.prefixConsumed, .groupCount, .instrWords, .escapeCode,
		.reservedPlace, .reservedCond, .loopEndMarker, .loopEarlyMarker,
		.slotEnable, .daluRegA, .daluRegB, .daluRegC, .aguReg);

	// Expected slot enables by condition code and true flag
	function automatic logic [15:0] cond(input logic [2:0] c, input logic t);
		case (c)
			3'h1: return t ? 16'h15 : 16'h2a;
			3'h2: return t ? 16'h3f : 16'h00;
			3'h3: return t ? 16'h00 : 16'h3f;
			3'h6: return t ? 16'h3f : 16'h2a;
			3'h7: return t ? 16'h2a : 16'h3f;
			default: return 16'h3f;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Offer one set, then wait a bounded time for the answer pulse
	task automatic send(input logic [15:0] a, input logic [15:0] b,
		input logic s, input logic t);
		int n;
		@(posedge clk);
		req <= 1'b1;
		w1In <= a;
		w2In <= b;
		startIn <= s;
		tIn <= t;
		@(posedge clk);
		req <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end while (decodeValid !== 1'b1 && n < 4);
		chk("decodeValid", decodeValid, 16'h1);
	endtask

	task automatic results;
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Watchdog: the whole sequence needs about a hundred cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		mismatches++;
		results();
	end

	initial
	begin
		{rst_b, req, tIn, w1In, w2In, daluForm, aguKind, aguCode} = '0;
		{daluFieldA, daluFieldB, daluFieldC} = '0;
		startIn = 1'b1;
		mismatches = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk("slotEnable", slotEnable, 16'h3f);
		// Every condition code against both flag values
		for (int c = 0; c < 8; c++)
			for (int t = 0; t < 2; t++)
			begin
				send(16'h3600 | 16'(c), 16'ha000, 1'b1, t[0]);
				chk("slotEnable", slotEnable, cond(c[2:0], t[0]));
				chk("reservedCond", reservedCond, 16'(c == 4 || c == 5));
			end
		// Every group count, escapes included
		for (int a = 0; a < 8; a++)
		begin
			send(16'h3000 | 16'(a << 9), 16'ha000, 1'b1, 1'b0);
			chk("groupCount", groupCount, 16'(a));
			chk("instrWords", instrWords, 16'(a < 2 ? 0 : a - 1));
			chk("escapeCode", escapeCode, 16'(a < 2));
			chk("prefixConsumed", prefixConsumed, 16'h1);
		end
		// Each loop marker on its own, so a swap shows up
		for (int k = 0; k < 2; k++)
		begin
			send(k ? 16'h3608 : 16'h3610, 16'ha000, 1'b1, 1'b0);
			chk("loopEarlyMarker", loopEarlyMarker, 16'(k == 0));
			chk("loopEndMarker", loopEndMarker, 16'(k));
			chk("prefixHit", prefixHit, 16'h1);
		end
		send(16'h3600, 16'ha000, 1'b0, 1'b0);
		chk("reservedPlace", reservedPlace, 16'h1);
		// Broken second-word tag or set first-word zero bit: not a prefix, whole set enabled
		for (int k = 0; k < 2; k++)
		begin
			send(k ? 16'h3702 : 16'h3602, k ? 16'ha000 : 16'h8000, 1'b1, 1'b0);
			chk("prefixHit", prefixHit, 16'h0);
			chk("prefixConsumed", prefixConsumed, 16'h0);
			chk("slotEnable", slotEnable, 16'h3f);
		end
		// Data banks: forms three, two, one, three on units 0 to 3
		@(posedge clk);
		daluForm <= {2'h2, 2'h0, 2'h1, 2'h2};
		daluFieldA <= {4{3'h5}};
		daluFieldB <= {4{3'h3}};
		daluFieldC <= {4{3'h1}};
		// Unit 1 operand 0 is the index pointer, so its check is reached
		aguKind <= {3'h3, 3'h5, 3'h0, 3'h0};
		aguCode <= {4'h1, 4'h3, 4'h2, 4'h3};
		send(16'h36e0, 16'hb335, 1'b1, 1'b0);
		chk("daluRegA", daluRegA, 16'h5d5d);
		chk("daluRegB", daluRegB, 16'hb33b);
		chk("daluRegC", daluRegC, 16'h1119);
		chk("aguReg", aguReg, 16'h93ab);
		// Address kinds with primary and secondary bits set apart
		@(posedge clk);
		aguKind <= {3'h1, 3'h4, 3'h2, 3'h1};
		aguCode <= {4'hc, 4'h4, 4'h2, 4'h5};
		send(16'h36c0, 16'ha011, 1'b1, 1'b0);
		chk("aguReg", aguReg, 16'hccad);
		chk("daluRegA", daluRegA, 16'h555d);
		chk("daluRegB", daluRegB, 16'h3333);
		// Back-to-back offers, each answered in turn
		@(posedge clk);
		req <= 1'b1;
		w1In <= 16'h3600;
		@(posedge clk);
		w1In <= 16'h3a00;
		@(posedge clk);
		req <= 1'b0;
		#1;
		chk("groupCount", groupCount, 16'h3);
		@(posedge clk);
		#1;
		chk("decodeValid", decodeValid, 16'h1);
		chk("groupCount", groupCount, 16'h5);
		results();
	end
endmodule

`default_nettype wire
